//--- dgp_board.sv
// Board model: external pin levels resolved against the port drivers
`timescale 1ns/100ps
module dgp_board
  import dgp_pkg::*;
(
  input wire logic [7:0] f_out_i,
  input wire logic [7:0] f_oe_i,
  input wire logic [7:0] f_ext_i,
  input wire logic [4:0] g_out_i,
  input wire logic [4:0] g_oe_i,
  input wire logic [5:0] g_ext_i,
  output logic [7:0] f_pin_o,
  output logic [5:0] g_pin_o
);
  // A driven pin shows the port level, an undriven one the board level
  assign f_pin_o = (f_out_i & f_oe_i) | (f_ext_i & ~f_oe_i);
  // Pin five has no driver, so the board alone sets it
  assign g_pin_o = {g_ext_i[5], (g_out_i & g_oe_i) | (g_ext_i[4:0] & ~g_oe_i)};
endmodule

//--- dgp_pkg.sv
// Package for the dual port block: register map, reset values, carriers
package dgp_pkg;
  localparam int DGP_AW = 5;
  localparam logic [4:0] DGP_OFF_F_DIR = 5'h00;
  localparam logic [4:0] DGP_OFF_F_PINS = 5'h04;
  localparam logic [4:0] DGP_OFF_F_LAT = 5'h08;
  localparam logic [4:0] DGP_OFF_G_DIR = 5'h0c;
  localparam logic [4:0] DGP_OFF_G_PINS = 5'h10;
  localparam logic [4:0] DGP_OFF_G_LAT = 5'h14;
  localparam logic [4:0] DGP_OFF_ANA = 5'h18;
  localparam logic [4:0] DGP_OFF_CMP = 5'h1c;
  localparam logic [7:0] DGP_F_DIR_RST = 8'hff;
  localparam logic [7:0] DGP_G_DIR_RST = 8'h1f;
  localparam logic [7:0] DGP_LAT_RST = 8'h00;
  localparam logic [7:0] DGP_ANA_RST = 8'h00;
  localparam logic [7:0] DGP_CMP_RST = 8'h07;
  localparam logic [7:0] DGP_G_DIR_MASK = 8'h1f;
  localparam logic [7:0] DGP_G_PIN_MASK = 8'h3f;
  localparam logic [3:0] DGP_ANA_ALL_DIG = 4'hf;
  localparam int DGP_ANA_PCFG_LSB = 0;
  localparam int DGP_CMP_MODE_LSB = 0;
  localparam int DGP_CMP_REF_BIT = 3;
  localparam logic [2:0] DGP_CMP_OUT_MODE = 3'h3;
  localparam int DGP_SYNC_STAGES = 2;
  typedef struct packed {
    logic c1_out;
    logic c2_out;
    logic ref_en;
  } dgp_cmp_s;
  typedef struct packed {
    logic enhanced_capture_unit_three_en;
    logic enhanced_capture_unit_three_out;
    logic p3a_en;
    logic p3a_out;
    logic ser_en;
    logic ser_out;
    logic ser_dir_out;
    logic capture_unit_four_en;
    logic capture_unit_four_out;
    logic p3d_en;
    logic p3d_out;
    logic capture_unit_five_en;
    logic capture_unit_five_out;
    logic p1d_en;
    logic p1d_out;
    logic pwm_shutdown;
  } dgp_periph_s;
endpackage

//--- dgp_regbit.sv
// Eight-bit software register with write mask and reset value
`timescale 1ns/100ps
module dgp_regbit
  import dgp_pkg::*;
#(
  parameter logic [7:0] RST = 8'h00,
  parameter logic [7:0] MASK = 8'hff
)
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] q_o
);
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      q_o <= RST & MASK;
    else if (we_i)
      q_o <= wdata_i & MASK;
  end
endmodule

//--- dgp_sync.sv
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/100ps
module dgp_sync
  import dgp_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_r <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

//--- dgp_top.sv
// Dual general-purpose port F/G with Wishbone register access
// Notes on behaviour
// - Direction bit one tri-states the pin driver, pin acts as input.
// - Direction bit zero drives the pin with its latch bit.
// - Latch register reads return stored latch, not pin level.
// - Port F has eight individually configurable pins.
// - Port G has six pins; unused high bits read zero.
// - After reset port F low seven pins are analog and read zero.
// - Analog selection disables the digital input path of a pin.
// - Analog selection leaves the digital output path working.
// - Routed comparator output replaces latch on an output pin.
// - Reference output enabled disables digital in and out of its pin.
// - Port F top pin feeds serial slave select when an input.
// - Peripheral direction override never writes the direction register.
// - Master clear disabled: input-only pin is plain digital input.
// - Master clear enabled: input-only pin read and latch read zero.
// - After reset port G pins are inputs; input-only pin per master clear.
// - Capture unit three output overrides latch; pin feeds its capture input.
// - Serial two transmit or clock overrides latch; clock input when input.
// - Capture units four and five outrank latch and shared PWM channel.
// - PWM channels override latch and tri-state during shutdown.
`timescale 1ns/100ps
module dgp_top
  import dgp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [DGP_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic master_clear_enable_cfg_i,
  input wire dgp_cmp_s cmp_i,
  input wire dgp_periph_s periph_i,
  input wire logic [7:0] port_f_in_i,
  output logic [7:0] port_f_out_o,
  output logic [7:0] port_f_oe_o,
  input wire logic [5:0] port_g_in_i,
  output logic [4:0] port_g_out_o,
  output logic [4:0] port_g_oe_o,
  output logic serial_slave_select_o,
  output logic capture_three_in_o,
  output logic serial_two_sync_clock_in_o,
  output logic serial_two_receive_o,
  output logic capture_four_in_o,
  output logic capture_five_in_o,
  output logic master_clear_input_o,
  output logic [6:0] analog_enable_o
);
  logic [7:0] f_dir_r;
  logic [7:0] f_lat_r;
  logic [7:0] g_dir_r;
  logic [7:0] g_lat_r;
  logic [7:0] ana_r;
  logic [7:0] cmp_r;
  logic [7:0] f_sync;
  logic [5:0] g_sync;
  logic [7:0] f_read;
  logic [7:0] g_read;
  logic [7:0] f_out_nxt;
  logic [7:0] f_oe_nxt;
  logic [4:0] g_out_nxt;
  logic [4:0] g_oe_nxt;
  logic [6:0] ana_sel;
  logic wr_en;
  logic master_clear_input_r;
  logic ack_r;
  logic [31:0] rdat_nxt;
  logic cmp_routed;

  // Single-cycle classic slave: ack the cycle after the strobe, drop after
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !ack_r;

  dgp_regbit #(.RST(DGP_F_DIR_RST), .MASK(8'hff)) u_f_dir (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .we_i(wr_en && wb_adr_i == DGP_OFF_F_DIR), .wdata_i(wb_dat_i[7:0]), .q_o(f_dir_r));
  // Writes to the pins address land in the latch, as on the latch address
  dgp_regbit #(.RST(DGP_LAT_RST), .MASK(8'hff)) u_f_lat (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .we_i(wr_en && (wb_adr_i == DGP_OFF_F_LAT || wb_adr_i == DGP_OFF_F_PINS)),
    .wdata_i(wb_dat_i[7:0]), .q_o(f_lat_r));
  dgp_regbit #(.RST(DGP_G_DIR_RST), .MASK(DGP_G_DIR_MASK)) u_g_dir (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .we_i(wr_en && wb_adr_i == DGP_OFF_G_DIR), .wdata_i(wb_dat_i[7:0]), .q_o(g_dir_r));
  dgp_regbit #(.RST(DGP_LAT_RST), .MASK(DGP_G_PIN_MASK)) u_g_lat (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .we_i(wr_en && (wb_adr_i == DGP_OFF_G_LAT || wb_adr_i == DGP_OFF_G_PINS)),
    .wdata_i(wb_dat_i[7:0]), .q_o(g_lat_r));
  dgp_regbit #(.RST(DGP_ANA_RST), .MASK(8'h3f)) u_ana (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .we_i(wr_en && wb_adr_i == DGP_OFF_ANA), .wdata_i(wb_dat_i[7:0]), .q_o(ana_r));
  // Comparator output flags are status, so only the low six bits are stored
  dgp_regbit #(.RST(DGP_CMP_RST), .MASK(8'h3f)) u_cmp (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .we_i(wr_en && wb_adr_i == DGP_OFF_CMP), .wdata_i(wb_dat_i[7:0]), .q_o(cmp_r));

  dgp_sync #(.W(8)) u_f_sync (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .d_i(port_f_in_i), .q_o(f_sync));
  dgp_sync #(.W(6)) u_g_sync (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .d_i(port_g_in_i), .q_o(g_sync));

  // Strap sampled after reset release, never inside the reset branch
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      master_clear_input_r <= 1'b1;
    else
      master_clear_input_r <= master_clear_enable_cfg_i;
  end

  // Low seven pins are all analog for field values up to 6 and all digital from 13 up;
  // a smaller field value leaves more channels analog
  always_comb
  begin
    logic [3:0] pcfg;
    pcfg = ana_r[DGP_ANA_PCFG_LSB +: 4];
    for (int i = 0; i < 7; i++)
      ana_sel[i] = (pcfg == DGP_ANA_ALL_DIG) ? 1'b0 : (5'(i) + 5'(pcfg) < 5'h0d);
  end
  assign analog_enable_o = ana_sel;
  assign cmp_routed = cmp_r[DGP_CMP_MODE_LSB +: 3] == DGP_CMP_OUT_MODE;

  // Port F pin drive
  always_comb
  begin
    f_out_nxt = f_lat_r;
    f_oe_nxt = ~f_dir_r;
    if (cmp_routed)
    begin
      f_out_nxt[1] = cmp_i.c2_out;
      f_out_nxt[2] = cmp_i.c1_out;
    end
    if (cmp_i.ref_en)
    begin
      f_oe_nxt[5] = 1'b0;
      f_out_nxt[5] = 1'b0;
    end
  end

  // Port G pin drive; the direction register is never written here
  always_comb
  begin
    g_out_nxt = g_lat_r[4:0];
    g_oe_nxt = ~g_dir_r[4:0];
    if (periph_i.enhanced_capture_unit_three_en)
      g_out_nxt[0] = periph_i.enhanced_capture_unit_three_out;
    else if (periph_i.p3a_en)
    begin
      g_out_nxt[0] = periph_i.p3a_out;
      if (periph_i.pwm_shutdown)
        g_oe_nxt[0] = 1'b0;
    end
    if (periph_i.ser_en)
    begin
      g_out_nxt[1] = periph_i.ser_out;
    end
    if (periph_i.ser_dir_out)
    begin
      g_oe_nxt[2] = 1'b1;
      g_out_nxt[2] = periph_i.ser_out;
    end
    if (periph_i.capture_unit_four_en)
      g_out_nxt[3] = periph_i.capture_unit_four_out;
    else if (periph_i.p3d_en)
    begin
      g_out_nxt[3] = periph_i.p3d_out;
      if (periph_i.pwm_shutdown)
        g_oe_nxt[3] = 1'b0;
    end
    if (periph_i.capture_unit_five_en)
      g_out_nxt[4] = periph_i.capture_unit_five_out;
    else if (periph_i.p1d_en)
    begin
      g_out_nxt[4] = periph_i.p1d_out;
      if (periph_i.pwm_shutdown)
        g_oe_nxt[4] = 1'b0;
    end
  end

  // Output pins come from flip-flops; one cycle behind the registers
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      port_f_out_o <= '0;
      port_f_oe_o <= '0;
      port_g_out_o <= '0;
      port_g_oe_o <= '0;
    end
    else
    begin
      port_f_out_o <= f_out_nxt;
      port_f_oe_o <= f_oe_nxt;
      port_g_out_o <= g_out_nxt;
      port_g_oe_o <= g_oe_nxt;
    end
  end

  // Pin read paths
  always_comb
  begin
    f_read = f_sync;
    for (int i = 0; i < 7; i++)
      if (ana_sel[i])
        f_read[i] = 1'b0;
    if (cmp_i.ref_en)
      f_read[5] = 1'b0;
    g_read = {2'b00, g_sync};
    if (master_clear_input_r)
      g_read[5] = 1'b0;
  end

  // Peripheral inputs fed from the synchronised pins
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      serial_slave_select_o <= 1'b0;
      capture_three_in_o <= 1'b0;
      serial_two_sync_clock_in_o <= 1'b0;
      serial_two_receive_o <= 1'b0;
      capture_four_in_o <= 1'b0;
      capture_five_in_o <= 1'b0;
      master_clear_input_o <= 1'b0;
    end
    else
    begin
      serial_slave_select_o <= f_dir_r[7] & f_sync[7];
      capture_three_in_o <= g_dir_r[0] & g_sync[0];
      serial_two_sync_clock_in_o <= g_dir_r[1] & g_sync[1];
      serial_two_receive_o <= g_dir_r[2] & g_sync[2];
      capture_four_in_o <= g_dir_r[3] & g_sync[3];
      capture_five_in_o <= g_dir_r[4] & g_sync[4];
      master_clear_input_o <= master_clear_input_r & g_sync[5];
    end
  end

  // Read mux; unmapped offsets read zero and still ack
  always_comb
  begin
    rdat_nxt = '0;
    case (wb_adr_i)
      DGP_OFF_F_DIR: rdat_nxt[7:0] = f_dir_r;
      DGP_OFF_F_PINS: rdat_nxt[7:0] = f_read;
      DGP_OFF_F_LAT: rdat_nxt[7:0] = f_lat_r;
      DGP_OFF_G_DIR: rdat_nxt[7:0] = g_dir_r;
      DGP_OFF_G_PINS: rdat_nxt[7:0] = g_read;
      DGP_OFF_G_LAT: rdat_nxt[7:0] = {2'b00, master_clear_input_r ? 1'b0 : g_lat_r[5], g_lat_r[4:0]};
      DGP_OFF_ANA: rdat_nxt[7:0] = ana_r;
      DGP_OFF_CMP: rdat_nxt[7:0] = {cmp_i.c2_out, cmp_i.c1_out, cmp_r[5:0]};
      default: rdat_nxt = '0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ack_r <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      wb_dat_o <= rdat_nxt;
    end
  end
  assign wb_ack_o = ack_r;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !ack_r;
  endsequence

  bus_ack_a: assert property (bus_req_s |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");
  dir_tristate_a: assert property (
    f_dir_r[0] |=> !port_f_oe_o[0])
    else $error("input pin driven");
  lat_drive_a: assert property (
    (!f_dir_r[0] && !ana_sel[0]) |=> port_f_oe_o[0] && port_f_out_o[0] == $past(f_lat_r[0]))
    else $error("output pin not latch value");
  lat_read_a: assert property (
    bus_req_s and (wb_adr_i == DGP_OFF_F_LAT) and !wb_we_i |=> wb_dat_o[7:0] == $past(f_lat_r))
    else $error("latch readback wrong");
  g_dir_high_a: assert property (g_dir_r[7:5] == 3'b000)
    else $error("unused direction bits set");
  ana_read_a: assert property (
    bus_req_s and (wb_adr_i == DGP_OFF_F_PINS) and ana_sel[3] |=> !wb_dat_o[3])
    else $error("analog pin reads digital level");
  ref_off_a: assert property (cmp_i.ref_en |=> !port_f_oe_o[5])
    else $error("reference pin driven");
  capture_unit_four_prio_a: assert property (
    periph_i.capture_unit_four_en |=> port_g_out_o[3] == $past(periph_i.capture_unit_four_out))
    else $error("capture four lost priority");
  pwm_shut_a: assert property (
    (!periph_i.capture_unit_five_en && periph_i.p1d_en && periph_i.pwm_shutdown) |=> !port_g_oe_o[4])
    else $error("pwm pin driven in shutdown");
  master_clear_input_read_a: assert property (
    bus_req_s and (wb_adr_i == DGP_OFF_G_PINS) and master_clear_input_r |=> !wb_dat_o[5])
    else $error("master clear pin read nonzero");

  // Register, pin and readback checks; all but sync_delay_a look one edge later
  sequence g_dir_wr_s;
    wr_en && wb_adr_i == DGP_OFF_G_DIR;
  endsequence

  dir_write_a: assert property (
    g_dir_wr_s |=> g_dir_r == ($past(wb_dat_i[7:0]) & DGP_G_DIR_MASK))
    else $error("direction write lost");
  dir_keep_a: assert property (
    !(wr_en && wb_adr_i == DGP_OFF_G_DIR) |=> $stable(g_dir_r))
    else $error("direction register changed without a write");
  ana_out_a: assert property (
    (ana_sel[4] && !f_dir_r[4]) |=> port_f_oe_o[4] && port_f_out_o[4] == $past(f_lat_r[4]))
    else $error("analog pin lost its output drive");
  cmp_route_a: assert property (
    (cmp_routed && !f_dir_r[1]) |=> port_f_out_o[1] == $past(cmp_i.c2_out))
    else $error("comparator output not on pin");
  ss_gate_a: assert property (!f_dir_r[7] |=> !serial_slave_select_o)
    else $error("slave select follows an output pin");
  master_clear_input_pin_a: assert property (!master_clear_input_r |=> !master_clear_input_o)
    else $error("master clear active while disabled");
  glat_master_clear_input_a: assert property (
    bus_req_s and (wb_adr_i == DGP_OFF_G_LAT) and master_clear_input_r |=> !wb_dat_o[5])
    else $error("input-only latch bit read nonzero");
  eccp_drive_a: assert property (
    periph_i.enhanced_capture_unit_three_en |=> port_g_out_o[0] == $past(periph_i.enhanced_capture_unit_three_out))
    else $error("capture three output lost");
  ser_drive_a: assert property (
    periph_i.ser_en |=> port_g_out_o[1] == $past(periph_i.ser_out))
    else $error("serial transmit not on pin");
  ser_data_a: assert property (
    periph_i.ser_dir_out |=> port_g_oe_o[2] && port_g_out_o[2] == $past(periph_i.ser_out))
    else $error("serial data pin not driven");
  sync_delay_a: assert property (
    $past(nrst_i, 2) |-> f_sync == $past(port_f_in_i, 2))
    else $error("pin read not two edges behind pin");
endmodule

//--- dual_gpio_port_f_g_bench.sv
// Self-checking bench for the dual general-purpose port block
`timescale 1ns/100ps
module dual_gpio_port_f_g_bench
  import dgp_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic mce = 1'b1;
  logic [4:0] adr = 5'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] dat;
  logic ack;
  dgp_cmp_s cmp = '0;
  dgp_periph_s per = '0;
  logic [7:0] fext = 8'hff;
  logic [5:0] gext = 6'h3f;
  logic [7:0] fpin, fout, foe;
  logic [5:0] gpin;
  logic [4:0] gout, goe;
  logic ss, c3, sck, mci, rx, c4, c5;
  logic [6:0] ana;
  int bad_count = 0;
  int cmp_count = 0;

  always #2 clk = ~clk;

  dgp_top u_dut (.core_clk_i(clk), .nrst_i(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat),
    .wb_ack_o(ack), .master_clear_enable_cfg_i(mce), .cmp_i(cmp), .periph_i(per),
    .port_f_in_i(fpin), .port_f_out_o(fout), .port_f_oe_o(foe), .port_g_in_i(gpin),
    .port_g_out_o(gout), .port_g_oe_o(goe), .serial_slave_select_o(ss),
    .capture_three_in_o(c3), .serial_two_sync_clock_in_o(sck), .serial_two_receive_o(rx),
    .capture_four_in_o(c4), .capture_five_in_o(c5), .master_clear_input_o(mci),
    .analog_enable_o(ana));

  dgp_board u_board (.f_out_i(fout), .f_oe_i(foe), .f_ext_i(fext), .g_out_i(gout),
    .g_oe_i(goe), .g_ext_i(gext), .f_pin_o(fpin), .g_pin_o(gpin));

  task automatic end_sim;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single cycle; the wait is bounded so a missing ack ends the run
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
    input logic s0, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= {24'h0, d};
    sel <= s0 ? 4'hf : 4'he;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      bad_count++;
      end_sim();
    end
    q = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 1'b1, q);
  endtask

  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, 1'b1, q);
    chk(q[7:0], e);
  endtask

  // Lets register updates reach the pins and pin levels pass the synchroniser
  task automatic settle;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic t_reset;
    settle;
    chk(foe, 8'h00);
    chk(8'(goe), 8'h00);
    chk(8'(ana), 8'h7f);
    chk(8'(mci), 8'h01);
    rc(DGP_OFF_F_DIR, 8'hff);
    rc(DGP_OFF_G_DIR, 8'h1f);
    rc(DGP_OFF_F_LAT, 8'h00);
    rc(DGP_OFF_ANA, 8'h00);
    rc(DGP_OFF_CMP, 8'h07);
    rc(DGP_OFF_F_PINS, 8'h80);
    rc(DGP_OFF_G_PINS, 8'h1f);
    $display("Test reset done");
  endtask

  task automatic t_drive;
    wr(DGP_OFF_F_LAT, 8'ha5);
    wr(DGP_OFF_F_DIR, 8'h0f);
    fext <= 8'h00;
    settle;
    chk(foe, 8'hf0);
    chk(fout & foe, 8'ha0);
    rc(DGP_OFF_F_LAT, 8'ha5);
    $display("Test drive done");
  endtask

  task automatic t_digital;
    wr(DGP_OFF_F_DIR, 8'hff);
    fext <= 8'h5a;
    settle;
    rc(DGP_OFF_F_PINS, 8'h00);
    wr(DGP_OFF_ANA, 8'h0a);
    settle;
    chk(8'(ana), 8'h07);
    rc(DGP_OFF_F_PINS, 8'h58);
    wr(DGP_OFF_ANA, 8'h0f);
    settle;
    rc(DGP_OFF_F_PINS, 8'h5a);
    chk(8'(ss), 8'h00);
    @(posedge clk);
    fext <= 8'hda;
    settle;
    chk(8'(ss), 8'h01);
    $display("Test digital done");
  endtask

  task automatic t_port_g;
    logic [31:0] q;
    wr(DGP_OFF_G_DIR, 8'hff);
    rc(DGP_OFF_G_DIR, 8'h1f);
    wr(DGP_OFF_G_LAT, 8'hff);
    rc(DGP_OFF_G_LAT, 8'h1f);
    bus(1'b1, DGP_OFF_G_LAT, 8'h00, 1'b0, q);
    mce <= 1'b0;
    gext <= 6'h2a;
    settle;
    rc(DGP_OFF_G_LAT, 8'h3f);
    rc(DGP_OFF_G_PINS, 8'h2a);
    chk(8'(mci), 8'h00);
    @(posedge clk);
    mce <= 1'b1;
    settle;
    rc(DGP_OFF_G_PINS, 8'h0a);
    $display("Test port g done");
  endtask

  task automatic t_cmp;
    wr(DGP_OFF_F_LAT, 8'h00);
    wr(DGP_OFF_F_DIR, 8'h00);
    wr(DGP_OFF_CMP, 8'h03);
    cmp <= 3'b100;
    settle;
    chk(fout & foe, 8'h04);
    @(posedge clk);
    cmp <= 3'b011;
    settle;
    chk(foe, 8'hdf);
    chk(fout & foe, 8'h02);
    rc(DGP_OFF_CMP, 8'h83);
    cmp <= '0;
    $display("Test comparator done");
  endtask

  task automatic t_periph;
    wr(DGP_OFF_G_LAT, 8'h00);
    wr(DGP_OFF_G_DIR, 8'h00);
    per <= 16'hcdc6;
    settle;
    chk(8'(gout & goe), 8'h1b);
    @(posedge clk);
    per <= 16'hcdc7;
    settle;
    chk(8'(goe), 8'h0f);
    rc(DGP_OFF_G_DIR, 8'h00);
    per <= 16'h0e00;
    gext <= 6'h03;
    wr(DGP_OFF_G_DIR, 8'h1f);
    settle;
    chk(8'(goe[2] & gout[2]), 8'h01);
    chk(8'({c3, sck}), 8'h03);
    chk(8'({rx, c4, c5}), 8'h04);
    rc(DGP_OFF_G_DIR, 8'h1f);
    per <= '0;
    $display("Test peripherals done");
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_drive;
    t_digital;
    t_port_g;
    t_cmp;
    t_periph;
    end_sim();
  end
endmodule
